//--- rtl/lp_consts.vh
// constants for the low-rate oversampling crossing path
`ifndef LP_CONSTS_VH
`define LP_CONSTS_VH
`define LP_OS_RATIO 3'h5
`define LP_OS_LAST 3'h4
`define LP_OS_MID 2
`define LP_WORD_W 40
`define LP_NARROW_W 20
`define LP_CHUNK_W 8
`define LP_NARROW_CHUNK 4
`define LP_Q_DEPTH 8
`define LP_Q_AW 3
`endif

//--- rtl/lp_dual_clock_queue.v
// word queue between two sampled clock domains, show-ahead read side
`timescale 1ns/1ps
`include "lp_consts.vh"
module lp_dual_clock_queue (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // fill side
  input wire wr_valid_i,
  input wire [`LP_WORD_W-1:0] wr_data_i,
  output wire wr_ready_o,
  // drain side
  input wire rd_ready_i,
  output wire rd_valid_o,
  output wire [`LP_WORD_W-1:0] rd_data_o
);
  reg [`LP_WORD_W-1:0] mem [0:`LP_Q_DEPTH-1];
  reg [`LP_Q_AW:0] wr_ptr;
  reg [`LP_Q_AW:0] rd_ptr;
  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[`LP_Q_AW-1:0] == rd_ptr[`LP_Q_AW-1:0]) &&
              (wr_ptr[`LP_Q_AW] != rd_ptr[`LP_Q_AW]);
  wire do_wr = wr_valid_i && !full;
  wire do_rd = rd_ready_i && !empty;

  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  // head word is held in flops, so show-ahead costs no extra stage
  assign rd_data_o = mem[rd_ptr[`LP_Q_AW-1:0]];

  always @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[`LP_Q_AW-1:0]] <= wr_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {(`LP_Q_AW+1){1'b0}};
      rd_ptr <= {(`LP_Q_AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // lp_dual_clock_queue

//--- rtl/lp_oversample_path.v
// low-rate 5x oversampling datapath with receive and transmit queues
// Notes on behaviour
// - receive oversampling ratio is fixed at five samples per bit
// - receive extraction is used only while the low-rate flag is set
// - word width is 20 bits (two symbols) or 40 bits (four symbols)
// - each extracted word comes with a one-cycle valid every fifth cycle
// - receive queue carries words from recovered to receive link clock
// - transmit queue carries words from transmit link to parallel clock
// - low rate: receive queue writes oversampler word on its valid pulse
// - normal rate: receive queue writes transceiver word every cycle
// - processor decides transmit low rate; then oversampler feeds output
// - normal rate: transmit output reads queue every cycle
// - transmit oversampler repeats each bit five times, word taken per five
// - low rate: enable pulse every fifth cycle reads transmit queue
`timescale 1ns/1ps
`include "lp_consts.vh"
module lp_oversample_path (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // outside clocks, sampled here
  input wire rx_rec_clk_i,
  input wire rx_link_clk_i,
  input wire tx_link_clk_i,
  input wire tx_par_clk_i,
  // mode
  input wire rx_low_rate_i,
  input wire tx_low_rate_i,
  input wire wide_i,
  // receive side
  input wire [`LP_WORD_W-1:0] rx_xcvr_data_i,
  output reg [`LP_WORD_W-1:0] rx_link_data_o,
  output reg rx_link_valid_o,
  // transmit side
  input wire [`LP_WORD_W-1:0] tx_link_data_i,
  input wire tx_link_valid_i,
  output wire tx_link_ready_o,
  output reg [`LP_WORD_W-1:0] tx_xcvr_data_o
);
  // middle sample of each five-sample group
  function [`LP_CHUNK_W-1:0] lp_pick_mid;
    input [`LP_WORD_W-1:0] d;
    integer k;
    begin
      lp_pick_mid = {`LP_CHUNK_W{1'b0}};
      for (k = 0; k < `LP_CHUNK_W; k = k + 1) begin
        lp_pick_mid[k] = d[5*k+`LP_OS_MID];
      end
    end
  endfunction

  // chunk of a word, most significant chunk at phase 0
  function [`LP_CHUNK_W-1:0] lp_chunk;
    input [`LP_WORD_W-1:0] w;
    input [2:0] ph;
    input wide;
    integer j;
    integer base;
    begin
      lp_chunk = {`LP_CHUNK_W{1'b0}};
      if (wide) begin
        base = (4 - ph) * `LP_CHUNK_W;
      end else begin
        base = (4 - ph) * `LP_NARROW_CHUNK;
      end
      for (j = 0; j < `LP_CHUNK_W; j = j + 1) begin
        if (wide || j < `LP_NARROW_CHUNK) begin
          lp_chunk[j] = w[base+j];
        end
      end
    end
  endfunction

  // each chunk bit repeated five times
  function [`LP_WORD_W-1:0] lp_repeat;
    input [`LP_CHUNK_W-1:0] c;
    integer j;
    integer r;
    begin
      lp_repeat = {`LP_WORD_W{1'b0}};
      for (j = 0; j < `LP_CHUNK_W; j = j + 1) begin
        for (r = 0; r < 5; r = r + 1) begin
          lp_repeat[5*j+r] = c[j];
        end
      end
    end
  endfunction

  // two-flop synchronisers plus one edge stage
  reg [3:0] clk_s1;
  reg [3:0] clk_s2;
  reg [3:0] clk_s3;
  reg [2:0] mode_s1;
  reg [2:0] mode_s2;
  reg [`LP_WORD_W-1:0] rx_d_s1;
  reg [`LP_WORD_W-1:0] rx_d_s2;
  reg [`LP_WORD_W-1:0] tx_d_s1;
  reg [`LP_WORD_W-1:0] tx_d_s2;
  reg tx_v_s1;
  reg tx_v_s2;
  wire [3:0] rise = clk_s2 & ~clk_s3;
  wire rec_edge = rise[0];
  wire rxl_edge = rise[1];
  wire txl_edge = rise[2];
  wire par_edge = rise[3];
  // band detection happens outside; flag only synchronised here
  wire rx_low = mode_s2[0];
  wire tx_low = mode_s2[1];
  wire wide = mode_s2[2];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_s1 <= 4'h0;
      clk_s2 <= 4'h0;
      clk_s3 <= 4'h0;
      mode_s1 <= 3'h0;
      mode_s2 <= 3'h0;
      tx_v_s1 <= 1'b0;
      tx_v_s2 <= 1'b0;
    end else begin
      clk_s1 <= {tx_par_clk_i, tx_link_clk_i, rx_link_clk_i, rx_rec_clk_i};
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      mode_s1 <= {wide_i, tx_low_rate_i, rx_low_rate_i};
      mode_s2 <= mode_s1;
      tx_v_s1 <= tx_link_valid_i;
      tx_v_s2 <= tx_v_s1;
    end
  end

  always @(posedge clk_i) begin
    rx_d_s1 <= rx_xcvr_data_i;
    rx_d_s2 <= rx_d_s1;
    tx_d_s1 <= tx_link_data_i;
    tx_d_s2 <= tx_d_s1;
  end

  // receive oversampler
  reg [2:0] rx_phase;
  reg [`LP_WORD_W-1:0] rx_acc;
  reg [`LP_WORD_W-1:0] rx_os_word;
  reg rx_os_valid;
  reg [`LP_WORD_W-1:0] next_rx_acc;
  wire [`LP_CHUNK_W-1:0] rx_mid = lp_pick_mid(rx_d_s2);

  always @* begin
    if (wide) begin
      next_rx_acc = {rx_acc[`LP_WORD_W-`LP_CHUNK_W-1:0], rx_mid};
    end else begin
      next_rx_acc = {{`LP_NARROW_W{1'b0}},
                     rx_acc[`LP_NARROW_W-`LP_NARROW_CHUNK-1:0],
                     rx_mid[`LP_NARROW_CHUNK-1:0]};
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_phase <= 3'h0;
      rx_acc <= {`LP_WORD_W{1'b0}};
      rx_os_word <= {`LP_WORD_W{1'b0}};
      rx_os_valid <= 1'b0;
    end else begin
      rx_os_valid <= 1'b0;
      if (rec_edge && rx_low) begin
        rx_acc <= next_rx_acc;
        if (rx_phase == `LP_OS_LAST) begin
          rx_phase <= 3'h0;
          rx_os_word <= next_rx_acc;
          rx_os_valid <= 1'b1;
        end else begin
          rx_phase <= rx_phase + 3'h1;
        end
      end else if (!rx_low) begin
        rx_phase <= 3'h0;
      end
    end
  end

  // receive queue: recovered side in, link side out
  wire rxq_wr = rx_low ? rx_os_valid : rec_edge;
  wire [`LP_WORD_W-1:0] rxq_wdata = rx_low ? rx_os_word : rx_d_s2;
  wire rxq_valid;
  wire [`LP_WORD_W-1:0] rxq_head;
  wire rxq_rd = rxl_edge && rxq_valid;

  lp_dual_clock_queue u_rx_queue (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_valid_i(rxq_wr),
    .wr_data_i(rxq_wdata),
    .wr_ready_o(),
    .rd_ready_i(rxq_rd),
    .rd_valid_o(rxq_valid),
    .rd_data_o(rxq_head)
  );

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_link_data_o <= {`LP_WORD_W{1'b0}};
      rx_link_valid_o <= 1'b0;
    end else begin
      rx_link_valid_o <= rxq_rd;
      if (rxq_rd) begin
        rx_link_data_o <= rxq_head;
      end
    end
  end

  // transmit queue: link side in, parallel side out
  reg [2:0] tx_phase;
  reg [`LP_WORD_W-1:0] tx_hold;
  wire txq_valid;
  wire [`LP_WORD_W-1:0] txq_head;
  wire tx_cen = par_edge && (tx_phase == 3'h0);
  wire txq_rd = tx_low ? tx_cen : par_edge;
  wire txq_wr = txl_edge && tx_v_s2;
  // word for this phase: fresh head at phase 0, held copy after
  wire [`LP_WORD_W-1:0] tx_cur = (tx_phase == 3'h0) ? txq_head : tx_hold;

  lp_dual_clock_queue u_tx_queue (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_valid_i(txq_wr),
    .wr_data_i(tx_d_s2),
    .wr_ready_o(tx_link_ready_o),
    .rd_ready_i(txq_rd),
    .rd_valid_o(txq_valid),
    .rd_data_o(txq_head)
  );

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_phase <= 3'h0;
      tx_hold <= {`LP_WORD_W{1'b0}};
      tx_xcvr_data_o <= {`LP_WORD_W{1'b0}};
    end else if (par_edge) begin
      if (tx_low) begin
        tx_phase <= (tx_phase == `LP_OS_LAST) ? 3'h0 : tx_phase + 3'h1;
        if (tx_phase == 3'h0) begin
          tx_hold <= txq_valid ? txq_head : {`LP_WORD_W{1'b0}};
        end
        // underrun sends zeros rather than a stale word
        if (tx_phase != 3'h0 || txq_valid) begin
          tx_xcvr_data_o <= lp_repeat(lp_chunk(tx_cur, tx_phase, wide));
        end else begin
          tx_xcvr_data_o <= {`LP_WORD_W{1'b0}};
        end
      end else begin
        tx_phase <= 3'h0;
        tx_xcvr_data_o <= txq_valid ? txq_head : {`LP_WORD_W{1'b0}};
      end
    end
  end
endmodule // lp_oversample_path

//--- bench/lp_path_sva.sv
// port assertions for the low-rate oversampling path
`timescale 1ns/1ps
module lp_path_sva (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // sampled pins and mode
  input wire rx_link_clk_i,
  input wire tx_link_clk_i,
  input wire tx_par_clk_i,
  input wire tx_low_rate_i,
  // outputs
  input wire [39:0] rx_link_data_o,
  input wire rx_link_valid_o,
  input wire tx_link_ready_o,
  input wire [39:0] tx_xcvr_data_o
);
  // bit n is the pin n+1 edges back; edges act 2 to 4 samples late
  reg [3:0] h_rl;
  reg [3:0] h_tl;
  reg [3:0] h_tp;
  always @(posedge clk_i) begin
    h_rl <= {h_rl[2:0], rx_link_clk_i};
    h_tl <= {h_tl[2:0], tx_link_clk_i};
    h_tp <= {h_tp[2:0], tx_par_clk_i};
  end
  function automatic bit rep_ok(input logic [39:0] w);
    rep_ok = 1'b1;
    for (int j = 0; j < 40; j++)
      if (w[j] != w[j - j % 5]) rep_ok = 1'b0;
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RST_CLR: assert property (disable iff (1'b0)
    sys_rst_i |=> !rx_link_valid_o && rx_link_data_o == 0 &&
    tx_xcvr_data_o == 0 && tx_link_ready_o) else $error("bad reset state");
  AST_VLD_ONE: assert property (
    rx_link_valid_o |=> !rx_link_valid_o[*4]) else $error("valid too long");
  AST_VLD_SRC: assert property (
    rx_link_valid_o |-> |h_rl[3:1]) else $error("valid off edge");
  AST_RX_HOLD: assert property (
    !$stable(rx_link_data_o) |-> rx_link_valid_o) else $error("rx moved");
  AST_TX_SRC: assert property (
    !$stable(tx_xcvr_data_o) |-> |h_tp[3:1]) else $error("tx moved");
  AST_RDY_FALL: assert property (
    $fell(tx_link_ready_o) |-> |h_tl[3:1]) else $error("full off edge");
  AST_RDY_RISE: assert property (
    $rose(tx_link_ready_o) |-> |h_tp[3:1]) else $error("read off edge");
  AST_TX_REP: assert property (
    tx_low_rate_i && $past(tx_low_rate_i, 20) |-> rep_ok(tx_xcvr_data_o))
    else $error("tx not repeated");
endmodule // lp_path_sva
bind lp_oversample_path lp_path_sva i_sva (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .rx_link_clk_i(rx_link_clk_i),
  .tx_link_clk_i(tx_link_clk_i), .tx_par_clk_i(tx_par_clk_i),
  .tx_low_rate_i(tx_low_rate_i), .rx_link_data_o(rx_link_data_o),
  .rx_link_valid_o(rx_link_valid_o), .tx_link_ready_o(tx_link_ready_o),
  .tx_xcvr_data_o(tx_xcvr_data_o));

//--- bench/lp_chan_model.sv
// free-running channel and link clocks, 320 ns period
`timescale 1ns/1ps
module lp_chan_model (
  // pin clocks
  output reg rec_clk_o = 1'b0,
  output reg rx_link_clk_o = 1'b0,
  output reg tx_link_clk_o = 1'b0,
  output reg par_clk_o = 1'b0
);
  // odd offsets keep pin edges clear of the sampling edge
  // offset applied once only, so every clock keeps the same period
  initial begin
    #7;
    forever #160 rec_clk_o = ~rec_clk_o;
  end
  initial begin
    #97;
    forever #160 rx_link_clk_o = ~rx_link_clk_o;
  end
  initial begin
    #131;
    forever #160 tx_link_clk_o = ~tx_link_clk_o;
  end
  initial begin
    #53;
    forever #160 par_clk_o = ~par_clk_o;
  end
endmodule // lp_chan_model

//--- bench/lp_oversample_path_test.sv
// self-checking bench for the low-rate oversampling path
`timescale 1ns/1ps
module lp_oversample_path_test;
  typedef struct packed {
    logic [2:0] md;
    logic [39:0] rx, tx, erx, etx;
    logic rdy;
    logic [7:0] np;
  } lp_row_t;
  lp_row_t r [0:3];
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg rx_low_rate_i = 1'b0, tx_low_rate_i = 1'b0, wide_i = 1'b1;
  reg tx_link_valid_i = 1'b0;
  reg [39:0] rx_xcvr_data_i = 40'h0, tx_link_data_i = 40'h0, last;
  reg [39:0] q [0:4];
  wire rx_rec_clk_i, rx_link_clk_i, tx_link_clk_i, tx_par_clk_i;
  wire [39:0] rx_link_data_o, tx_xcvr_data_o;
  wire rx_link_valid_o, tx_link_ready_o;
  integer fails = 0, tests_run = 0, npulse = 0, nrdy = 0, i, nq;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (rx_link_valid_o === 1'b1) npulse <= npulse + 1;
    if (tx_link_ready_o === 1'b1) nrdy <= nrdy + 1;
  end
  lp_chan_model i_chan (.rec_clk_o(rx_rec_clk_i),
    .rx_link_clk_o(rx_link_clk_i), .tx_link_clk_o(tx_link_clk_i),
    .par_clk_o(tx_par_clk_i));
  lp_oversample_path i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rx_rec_clk_i(rx_rec_clk_i), .rx_link_clk_i(rx_link_clk_i),
    .tx_link_clk_i(tx_link_clk_i), .tx_par_clk_i(tx_par_clk_i),
    .rx_low_rate_i(rx_low_rate_i), .tx_low_rate_i(tx_low_rate_i),
    .wide_i(wide_i), .rx_xcvr_data_i(rx_xcvr_data_i),
    .rx_link_data_o(rx_link_data_o), .rx_link_valid_o(rx_link_valid_o),
    .tx_link_data_i(tx_link_data_i), .tx_link_valid_i(tx_link_valid_i),
    .tx_link_ready_o(tx_link_ready_o), .tx_xcvr_data_o(tx_xcvr_data_o));
  function [39:0] rep5(input [7:0] c);
    for (int j = 0; j < 40; j++)
      rep5[j] = c[j / 5];
  endfunction
  task chk(input [39:0] got, input [39:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // the run needs about 4240 cycles
  initial begin
    repeat (8000) @(posedge clk_i);
    fails = fails + 1;
    complete_run;
  end
  initial begin
    r[0] = {3'h1, 40'h123456789A, 40'h0FEDCBA987, 40'h123456789A,
      40'h0FEDCBA987, 1'b1, 8'h32};
    r[1] = {3'h7, rep5(8'h3C), {5{8'hA5}}, {5{8'h3C}}, rep5(8'hA5),
      1'b0, 8'h0A};
    // outer samples of each group inverted: only the middle one may count
    r[2] = {3'h6, rep5(~8'h09) ^ {8{5'b00100}}, 40'h66666, 40'h99999,
      rep5(8'h06), 1'b0, 8'h0A};
    r[3] = {3'h3, 40'h5555AAAA33, {5{8'hA5}}, 40'h5555AAAA33, rep5(8'hA5),
      1'b0, 8'h32};
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // constant words make the result independent of sampling phase
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_i);
      {rx_low_rate_i, tx_low_rate_i, wide_i} <= r[i].md;
      rx_xcvr_data_i <= r[i].rx;
      tx_link_data_i <= r[i].tx;
      tx_link_valid_i <= 1'b1;
      repeat (600) @(posedge clk_i);
      #1;
      npulse = 0;
      nrdy = 0;
      repeat (400) @(posedge clk_i);
      #1;
      chk(rx_link_data_o, r[i].erx);
      chk(tx_xcvr_data_o, r[i].etx);
      chk({39'h0, r[i].rdy ? nrdy > 390 : nrdy < 100}, 40'h1);
      chk({39'h0, npulse - r[i].np + 2 < 5}, 40'h1);
    end
    @(posedge clk_i);
    tx_link_valid_i <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(tx_xcvr_data_o | rx_link_data_o, 40'h0);
    chk({39'h0, tx_link_ready_o}, 40'h1);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    tx_link_data_i <= 40'h1122334455;
    // valid spans exactly one link edge
    @(negedge tx_link_clk_i);
    @(posedge clk_i);
    tx_link_valid_i <= 1'b1;
    @(negedge tx_link_clk_i);
    @(posedge clk_i);
    tx_link_valid_i <= 1'b0;
    nq = 0;
    last = 40'h0;
    repeat (200) begin
      @(posedge clk_i);
      #1;
      if (tx_xcvr_data_o !== last && tx_xcvr_data_o !== 40'h0 && nq < 5) begin
        q[nq] = tx_xcvr_data_o;
        nq = nq + 1;
      end
      last = tx_xcvr_data_o;
    end
    for (i = 0; i < 5; i = i + 1)
      chk(q[i], rep5(tx_link_data_i[39 - 8 * i -: 8]));
    complete_run;
  end
endmodule // lp_oversample_path_test
